// ---- hw/dual_autoreload_pwm_timer.sv ----
// dual 12-bit autoreload pwm timer with dead time and break, axi4-lite registers
//
// Local design decisions: the address map and register access over AXI4-Lite.
module dual_autoreload_pwm_timer (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    // register bus
    input  wire pwm_timer_pkg::axil_req_s   axi_req,
    output      pwm_timer_pkg::axil_rsp_s   axi_rsp,
    // break pins
    input  wire logic [1:0]                 break_input_pin,
    // pwm pins
    output      logic [3:0]                 pulse_output,
    output      logic [3:0]                 pulse_output_oe
);

    pwm_timer_pkg::timer_state_s st;
    pwm_timer_pkg::timer_state_s n;

    logic        wr_go;
    logic [32:0] rd_w;
    logic [32:0] wr_old;
    logic [31:0] wmask;
    logic [31:0] wv;
    logic [1:0]  force_p;
    logic [1:0]  run;
    logic [1:0]  ovf;
    logic        halt;
    logic        brk1;
    logic        brk2;
    logic [3:0]  brk_ch;
    logic [3:0]  lvl;
    logic        dt_on;
    logic        dt_zero;
    logic [1:0]  duty_idx;
    logic        src;

    ////////////////////////////////////////////////////////////////////////////////
    // register read view; bit 32 flags an unmapped address
    function automatic logic [32:0] rd_word(input pwm_timer_pkg::timer_state_s s,
                                            input logic [7:0] a);
        logic [32:0] r;
        logic [1:0]  di;
        r  = '0;
        di = a[3:2] + 2'h1;
        unique case (a)
            pwm_timer_pkg::OFS_CTRL:    r[2:0]  = {s.xfer, s.mode};
            pwm_timer_pkg::OFS_RELOAD1: r[11:0] = s.reload[0];
            pwm_timer_pkg::OFS_RELOAD2: r[11:0] = s.reload[1];
            pwm_timer_pkg::OFS_DUTY0,
            pwm_timer_pkg::OFS_DUTY1,
            pwm_timer_pkg::OFS_DUTY2,
            pwm_timer_pkg::OFS_DUTY3:   r[11:0] = s.duty_pre[di];
            pwm_timer_pkg::OFS_OUTC:    r[7:0]  = {s.pol_pre, s.oe};
            pwm_timer_pkg::OFS_DEADT:   r[7:0]  = {s.dt_enable, s.dt_count};
            pwm_timer_pkg::OFS_BRK1:    r[7:0]  = {s.brk_flag[0], s.brk_sel[0],
                                                   s.brk_lvl[0], s.brk_en[0], s.pattern};
            pwm_timer_pkg::OFS_BRK2:    r[7:4]  = {s.brk_flag[1], s.brk_sel[1],
                                                   s.brk_lvl[1], s.brk_en[1]};
            pwm_timer_pkg::OFS_BREN:    r[1:0]  = s.bren;
            pwm_timer_pkg::OFS_CNT1:    r[11:0] = s.cnt[0];
            pwm_timer_pkg::OFS_CNT2:    r[11:0] = s.cnt[1];
            pwm_timer_pkg::OFS_STAT:    r[15:0] = {s.dt_act, s.pol_act, s.pin};
            default:                    r[32]   = 1'b1;
        endcase
        return r;
    endfunction : rd_word

    ////////////////////////////////////////////////////////////////////////////////
    // bus handshakes: one write and one read in flight
    always_comb begin
        axi_rsp.awready = !st.aw_full && !st.bvalid;
        axi_rsp.wready  = !st.w_full && !st.bvalid;
        axi_rsp.bvalid  = st.bvalid;
        axi_rsp.bresp   = st.bresp;
        axi_rsp.arready = !st.rvalid;
        axi_rsp.rvalid  = st.rvalid;
        axi_rsp.rdata   = st.rdata;
        axi_rsp.rresp   = st.rresp;
    end

    assign pulse_output    = st.pin;
    assign pulse_output_oe = st.pin_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        n        = st;
        force_p  = 2'h0;
        wr_go    = st.aw_full && st.w_full && !st.bvalid;
        wr_old   = rd_word(st, st.awaddr);
        rd_w     = rd_word(st, axi_req.araddr);
        duty_idx = st.awaddr[3:2] + 2'h1;
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{st.wstrb[b]}};
        end
        wv = (wr_old[31:0] & ~wmask) | (st.wdata & wmask);

        if (axi_req.awvalid && axi_rsp.awready) begin
            n.aw_full = 1'b1;
            n.awaddr  = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            n.w_full = 1'b1;
            n.wdata  = axi_req.wdata;
            n.wstrb  = axi_req.wstrb;
        end
        if (st.bvalid && axi_req.bready) begin
            n.bvalid = 1'b0;
        end
        if (st.rvalid && axi_req.rready) begin
            n.rvalid = 1'b0;
        end
        if (axi_req.arvalid && axi_rsp.arready) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_w[31:0];
            n.rresp  = rd_w[32] ? pwm_timer_pkg::RESP_SLV : pwm_timer_pkg::RESP_OKAY;
        end

        if (wr_go) begin
            n.aw_full = 1'b0;
            n.w_full  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = wr_old[32] ? pwm_timer_pkg::RESP_SLV : pwm_timer_pkg::RESP_OKAY;
            unique case (st.awaddr)
                pwm_timer_pkg::OFS_CTRL: begin
                    n.mode  = wv[pwm_timer_pkg::CTRL_MODE];
                    n.xfer  = wv[pwm_timer_pkg::CTRL_XFER +: 2];
                    // force bits act once and are not stored
                    force_p = wv[pwm_timer_pkg::CTRL_FORCE +: 2];
                end
                pwm_timer_pkg::OFS_RELOAD1: n.reload[0] = wv[11:0];
                pwm_timer_pkg::OFS_RELOAD2: n.reload[1] = wv[11:0];
                pwm_timer_pkg::OFS_DUTY0,
                pwm_timer_pkg::OFS_DUTY1,
                pwm_timer_pkg::OFS_DUTY2,
                pwm_timer_pkg::OFS_DUTY3: n.duty_pre[duty_idx] = wv[11:0];
                pwm_timer_pkg::OFS_OUTC: begin
                    n.oe      = wv[3:0];
                    n.pol_pre = wv[pwm_timer_pkg::OUTC_POL +: 4];
                end
                pwm_timer_pkg::OFS_DEADT: begin
                    n.dt_count  = wv[6:0];
                    n.dt_enable = wv[pwm_timer_pkg::DT_EN_BIT];
                end
                pwm_timer_pkg::OFS_BRK1: begin
                    n.pattern     = wv[3:0];
                    n.brk_en[0]   = wv[pwm_timer_pkg::BRK_PIN_EN];
                    n.brk_lvl[0]  = wv[pwm_timer_pkg::BRK_LEVEL];
                    n.brk_sel[0]  = wv[pwm_timer_pkg::BRK_SEL];
                    n.brk_flag[0] = wv[pwm_timer_pkg::BRK_FLAG];
                end
                pwm_timer_pkg::OFS_BRK2: begin
                    n.brk_en[1]   = wv[pwm_timer_pkg::BRK_PIN_EN];
                    n.brk_lvl[1]  = wv[pwm_timer_pkg::BRK_LEVEL];
                    n.brk_sel[1]  = wv[pwm_timer_pkg::BRK_SEL];
                    n.brk_flag[1] = wv[pwm_timer_pkg::BRK_FLAG];
                end
                pwm_timer_pkg::OFS_BREN: n.bren = wv[1:0];
                default: ;
            endcase
        end

        // pin detection after the software write, so a set beats a clear
        for (int j = 0; j < 2; j++) begin
            if (st.brk_en[j] && break_input_pin[st.brk_sel[j]] == st.brk_lvl[j]) begin
                n.brk_flag[j] = 1'b1;
            end
        end

        brk1   = (|n.brk_flag) && n.bren[0];
        brk2   = (|n.brk_flag) && (n.mode ? n.bren[1] : n.bren[0]);
        halt   = (|n.brk_flag) && (|n.bren);
        brk_ch = {brk2, brk2, brk1, brk1};
        run    = {st.mode, 1'b1};

        // counters; force acts like an overflow
        for (int k = 0; k < 2; k++) begin
            ovf[k] = run[k] && !halt && (st.cnt[k] == pwm_timer_pkg::CNT_MAX || force_p[k]);
            if (halt) begin
                if (k == 0 ? brk1 : brk2) begin
                    n.cnt[k] = '0;
                end
            end else if (!run[k]) begin
                n.cnt[k] = '0;
            end else if (ovf[k]) begin
                n.cnt[k] = st.reload[k];
            end else begin
                n.cnt[k] = st.cnt[k] + 12'h001;
            end
        end

        // transfer and waveform per channel
        for (int i = 0; i < 4; i++) begin
            src = (i >= 2) && st.mode;
            if (ovf[src] && st.xfer[src]) begin
                n.duty_act[i] = st.duty_pre[i];
                n.pol_act[i]  = st.pol_pre[i];
            end
            // no match once duty sits at or below reload: level stays high
            if (ovf[src]) begin
                n.raw[i] = 1'b1;
            end else if (n.cnt[src] == st.duty_act[i]) begin
                n.raw[i] = 1'b0;
            end
        end

        // dead time value only moves at an overflow so a cycle is never cut short
        if (ovf[0]) begin
            n.dt_act = {st.dt_enable, st.dt_count};
        end
        dt_on   = st.dt_act[7] && st.dt_act[6:0] != '0;
        dt_zero = st.dt_act[7] && st.dt_act[6:0] == '0;
        if (n.raw[0] != st.raw[0]) begin
            n.dly = st.dt_act[6:0];
        end else if (st.dly != '0) begin
            n.dly = st.dly - 7'h01;
        end
        lvl    = n.raw;
        lvl[0] = dt_on ? (n.raw[0] && n.dly == '0) : n.raw[0];
        lvl[1] = dt_on ? (!n.raw[0] && n.dly == '0) : n.raw[1];

        // polarity after dead time: inverted pairs may overlap
        lvl = lvl ^ n.pol_act;
        if (dt_zero) begin
            lvl[1:0] = 2'h0;
        end

        for (int i = 0; i < 4; i++) begin
            if (!n.oe[i]) begin
                n.pin[i] = 1'b0;
            end else if (brk_ch[i]) begin
                n.pin[i] = n.pattern[i];
            end else begin
                n.pin[i] = lvl[i];
            end
        end
        n.pin_oe = n.oe;

        if (halt) begin
            n.reload   = '0;
            n.duty_pre = '0;
            n.duty_act = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= pwm_timer_pkg::STATE_RST;
        end else begin
            st <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    wrap_reload_a: assert property ((ovf[0] && !force_p[0]) |=>
        st.cnt[0] == $past(st.reload[0]))
        else $error("counter 1 did not reload at overflow");

    // the edge that releases reset still holds the counter, so it is left out
    count_step_a: assert property ((rst_n && !ovf[0] && !halt) |=>
        st.cnt[0] == $past(st.cnt[0]) + 12'h001)
        else $error("counter 1 did not step by one");

    duty_hold_a: assert property ((!(ovf[0] && st.xfer[0]) && !halt) |=>
        $stable(st.duty_act[0]))
        else $error("active duty changed without transfer");

    pol_hold_a: assert property (!(ovf[0] && st.xfer[0]) |=>
        $stable(st.pol_act[0]))
        else $error("polarity changed outside overflow");

    pwm_rise_a: assert property (ovf[0] |=> st.raw[0] && st.cnt[0] == $past(st.reload[0]))
        else $error("channel 0 not high after overflow");

    pwm_fall_a: assert property ((st.cnt[0] == st.duty_act[0]
        && st.cnt[0] != st.reload[0] && !$past(force_p[0])) |-> !st.raw[0])
        else $error("channel 0 high at duty match");

    brk_detect_a: assert property ((st.brk_en[0]
        && break_input_pin[st.brk_sel[0]] == st.brk_lvl[0]) |=> st.brk_flag[0])
        else $error("break pin level did not set flag");

    brk_pattern_a: assert property (((|st.brk_flag) && st.bren[0] && st.oe[0])
        |-> st.pin[0] == st.pattern[0] && st.pin_oe[0])
        else $error("break pattern not on channel 0");

    brk_clear_a: assert property (((|st.brk_flag) && (|st.bren)) |->
        st.reload == '0 && st.duty_act == '0 && st.duty_pre == '0)
        else $error("break left reload or duty values");

    oe_off_a: assert property (!st.oe[2] |-> !st.pin[2] && !st.pin_oe[2])
        else $error("disabled output driven");

    dt_zero_a: assert property ((st.dt_act == 8'h80 && !(|st.brk_flag) && ovf[0])
        |-> ##1 (st.dt_act != 8'h80 || st.pin[1:0] == 2'h0))
        else $error("dead-time outputs not low with zero count");

    single_mode_a: assert property (!st.mode |=> st.cnt[1] == '0)
        else $error("counter 2 ran in single-timer mode");

    ////////////////////////////////////////////////////////////////////////////////
    // force, second counter group and single-mode break spread
    force_load_a: assert property ((force_p[0] && !halt) |=>
        st.cnt[0] == $past(st.reload[0]))
        else $error("forced update did not reload counter 1");

    group_duty_a: assert property ((st.mode && !(ovf[1] && st.xfer[1]) && !halt) |=>
        $stable(st.duty_act[2]))
        else $error("channel 2 duty moved without counter 2 transfer");

    group_pol_a: assert property ((st.mode && !(ovf[1] && st.xfer[1])) |=>
        $stable(st.pol_act[3]))
        else $error("channel 3 polarity moved without counter 2 transfer");

    single_brk_a: assert property ((!st.mode && (|st.brk_flag) && st.bren == 2'h1
        && st.oe[3]) |-> st.pin[3] == st.pattern[3])
        else $error("single-mode break did not reach channel 3");

endmodule : dual_autoreload_pwm_timer

// ---- hw/pwm_timer_pkg.sv ----
// package: register map, field layout, state record and bus carriers of the pwm timer
package pwm_timer_pkg;

    localparam int unsigned AW     = 8;
    localparam int unsigned CW     = 12;
    localparam int unsigned DTW    = 7;
    localparam int unsigned NCH    = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [AW-1:0] OFS_CTRL    = 8'h00;
    localparam logic [AW-1:0] OFS_RELOAD1 = 8'h04;
    localparam logic [AW-1:0] OFS_RELOAD2 = 8'h08;
    localparam logic [AW-1:0] OFS_DUTY0   = 8'h0c;
    localparam logic [AW-1:0] OFS_DUTY1   = 8'h10;
    localparam logic [AW-1:0] OFS_DUTY2   = 8'h14;
    localparam logic [AW-1:0] OFS_DUTY3   = 8'h18;
    localparam logic [AW-1:0] OFS_OUTC    = 8'h1c;
    localparam logic [AW-1:0] OFS_DEADT   = 8'h20;
    localparam logic [AW-1:0] OFS_BRK1    = 8'h24;
    localparam logic [AW-1:0] OFS_BRK2    = 8'h28;
    localparam logic [AW-1:0] OFS_BREN    = 8'h2c;
    localparam logic [AW-1:0] OFS_CNT1    = 8'h30;
    localparam logic [AW-1:0] OFS_CNT2    = 8'h34;
    localparam logic [AW-1:0] OFS_STAT    = 8'h38;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned CTRL_MODE   = 0;
    localparam int unsigned CTRL_XFER   = 1;
    localparam int unsigned CTRL_FORCE  = 3;
    localparam int unsigned OUTC_POL    = 4;
    localparam int unsigned DT_EN_BIT   = 7;
    localparam int unsigned BRK_PIN_EN  = 4;
    localparam int unsigned BRK_LEVEL   = 5;
    localparam int unsigned BRK_SEL     = 6;
    localparam int unsigned BRK_FLAG    = 7;

    localparam logic [CW-1:0] CNT_MAX   = 12'hfff;
    localparam logic [1:0]    XFER_RST  = 2'h3;
    localparam logic [1:0]    RESP_OKAY = 2'h0;
    localparam logic [1:0]    RESP_SLV  = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic          awvalid;
        logic [AW-1:0] awaddr;
        logic          wvalid;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bready;
        logic          arvalid;
        logic [AW-1:0] araddr;
        logic          rready;
    } axil_req_s;

    typedef struct packed {
        logic          awready;
        logic          wready;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
    } axil_rsp_s;

    typedef struct packed {
        logic                     aw_full;
        logic [AW-1:0]            awaddr;
        logic                     w_full;
        logic [31:0]              wdata;
        logic [3:0]               wstrb;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
        logic                     mode;
        logic [1:0]               xfer;
        logic                     dt_enable;
        logic [DTW-1:0]           dt_count;
        logic [DTW:0]             dt_act;
        logic [NCH-1:0]           oe;
        logic [NCH-1:0]           pol_pre;
        logic [NCH-1:0]           pol_act;
        logic [1:0][CW-1:0]       reload;
        logic [1:0][CW-1:0]       cnt;
        logic [NCH-1:0][CW-1:0]   duty_pre;
        logic [NCH-1:0][CW-1:0]   duty_act;
        logic [NCH-1:0]           raw;
        logic [DTW-1:0]           dly;
        logic [NCH-1:0]           pin;
        logic [NCH-1:0]           pin_oe;
        logic [1:0]               brk_en;
        logic [1:0]               brk_lvl;
        logic [1:0]               brk_sel;
        logic [1:0]               brk_flag;
        logic [NCH-1:0]           pattern;
        logic [1:0]               bren;
    } timer_state_s;

    localparam timer_state_s STATE_RST = '{xfer: XFER_RST, default: '0};

endpackage : pwm_timer_pkg

// ---- testbench/dual_autoreload_pwm_timer_tb.sv ----
// testbench: register bus traffic, pwm waveform, dead time and break checks
module dual_autoreload_pwm_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                     ref_clk;
    logic                     rst_n;
    pwm_timer_pkg::axil_req_s axi_req;
    pwm_timer_pkg::axil_rsp_s axi_rsp;
    logic [1:0]               break_input_pin;
    logic [3:0]               pulse_output;
    logic [3:0]               pulse_output_oe;
    logic                     trip;
    int                       overlap_cnt;
    int                       n_fail;
    int                       check_count;
    int                       p, k, d, p2, hi, per, ov;
    logic [31:0]              rd;
    logic [1:0]               rsp;

    dual_autoreload_pwm_timer dual_autoreload_pwm_timer_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .break_input_pin(break_input_pin), .pulse_output(pulse_output),
        .pulse_output_oe(pulse_output_oe));
    half_bridge_stage half_bridge_stage_i (
        .ref_clk(ref_clk), .pulse_output(pulse_output), .pulse_output_oe(pulse_output_oe),
        .trip(trip), .break_input_pin(break_input_pin), .overlap_cnt(overlap_cnt));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // a wait that runs out counts as a mismatch and ends the run
    task automatic give_up();
        chk(32'h0, 32'h1);
        end_of_test();
    endtask : give_up

    ////////////////////////////////////////////////////////////////////////////////
    // ready is stable from the falling edge up to the rising edge that samples it
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
        int   n;
        logic aw_h, w_h, b_h;
        n = 0;
        @(posedge ref_clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr  <= a;
        axi_req.wvalid  <= 1'b1;
        axi_req.wdata   <= dat;
        axi_req.wstrb   <= 4'hf;
        axi_req.bready  <= 1'b1;
        do begin
            @(negedge ref_clk);
            aw_h = axi_req.awvalid & axi_rsp.awready;
            w_h  = axi_req.wvalid & axi_rsp.wready;
            b_h  = axi_req.bready & axi_rsp.bvalid;
            resp = axi_rsp.bresp;
            @(posedge ref_clk);
            if (aw_h) axi_req.awvalid <= 1'b0;
            if (w_h) axi_req.wvalid <= 1'b0;
            if (b_h) axi_req.bready <= 1'b0;
            n++;
        end while (!b_h && n < 64);
        if (!b_h) give_up();
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
        int   n;
        logic ar_h, r_h;
        n = 0;
        @(posedge ref_clk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= a;
        axi_req.rready  <= 1'b1;
        do begin
            @(negedge ref_clk);
            ar_h = axi_req.arvalid & axi_rsp.arready;
            r_h  = axi_req.rready & axi_rsp.rvalid;
            dat  = axi_rsp.rdata;
            resp = axi_rsp.rresp;
            @(posedge ref_clk);
            if (ar_h) axi_req.arvalid <= 1'b0;
            if (r_h) axi_req.rready <= 1'b0;
            n++;
        end while (!r_h && n < 64);
        if (!r_h) give_up();
    endtask : bus_rd

    ////////////////////////////////////////////////////////////////////////////////
    // one whole period from a rising edge of the pin: cycles high, cycles in total
    task automatic measure(input int ch, output int hi, output int per);
        int n;
        hi = 0;
        per = 0;
        n = 0;
        while (pulse_output[ch] !== 1'b0 && n < 9000) begin @(posedge ref_clk); #1; n++; end
        while (pulse_output[ch] !== 1'b1 && n < 9000) begin @(posedge ref_clk); #1; n++; end
        while (pulse_output[ch] === 1'b1 && n < 9000) begin
            @(posedge ref_clk); #1; n++; hi++; per++;
        end
        while (pulse_output[ch] === 1'b0 && n < 9000) begin @(posedge ref_clk); #1; n++; per++; end
        if (n >= 9000) give_up();
    endtask : measure

    task automatic hold_chk(input logic [3:0] mask, input logic [3:0] val, input int cyc);
        logic ok;
        ok = 1'b1;
        repeat (cyc) begin
            @(posedge ref_clk);
            #1;
            ok &= ((pulse_output & mask) === val);
        end
        chk(32'(ok), 32'h1);
    endtask : hold_chk

    task automatic wait_pins(input logic [3:0] val);
        int n;
        n = 0;
        while (pulse_output !== val && n < 32) begin @(posedge ref_clk); #1; n++; end
        chk(32'(pulse_output), 32'(val));
        if (n >= 32) end_of_test();
    endtask : wait_pins

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h4c48));
        axi_req = '0;
        trip = 1'b0;
        rst_n = 1'b0;
        n_fail = 0;
        check_count = 0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus_rd(pwm_timer_pkg::OFS_CTRL, rd, rsp);
        chk(rd, 32'h6);
        bus_rd(pwm_timer_pkg::OFS_CNT1, rd, rsp);
        chk(32'(rd < 32'h10), 32'h1);
        bus_rd(8'h3c, rd, rsp);
        chk(32'(rsp), 32'(pwm_timer_pkg::RESP_SLV));
        // short random periods keep the run brief; reload stays at or below 4072
        p = 24 + $urandom % 24;
        k = 4 + $urandom % (p - 8);
        d = 1 + $urandom % 3;
        bus_wr(pwm_timer_pkg::OFS_RELOAD1, 32'(4096 - p), rsp);
        bus_wr(pwm_timer_pkg::OFS_DUTY0, 32'(4096 - p + k), rsp);
        bus_wr(pwm_timer_pkg::OFS_DUTY1, 32'(4096 - p + k), rsp);
        bus_wr(pwm_timer_pkg::OFS_DUTY3, 32'(4096 - p), rsp);
        bus_wr(pwm_timer_pkg::OFS_OUTC, 32'h2f, rsp);
        bus_wr(pwm_timer_pkg::OFS_CTRL, 32'h6, rsp);
        bus_wr(pwm_timer_pkg::OFS_CTRL, 32'h6, rsp);
        measure(0, hi, per);
        measure(0, hi, per);
        chk(32'(per), 32'(p));
        chk(32'(hi), 32'(k));
        measure(1, hi, per);
        measure(1, hi, per);
        chk(32'(hi), 32'(p - k));
        hold_chk(4'h8, 4'h8, p);
        bus_wr(pwm_timer_pkg::OFS_OUTC, 32'hf, rsp);
        bus_wr(pwm_timer_pkg::OFS_DEADT, 32'(8'h80 | d), rsp);
        measure(0, hi, per);
        measure(0, hi, per);
        chk(32'(hi), 32'(k - d));
        ov = overlap_cnt;
        measure(1, hi, per);
        measure(1, hi, per);
        chk(32'(hi), 32'(p - k - d));
        chk(32'(overlap_cnt - ov), 32'h0);
        bus_wr(pwm_timer_pkg::OFS_DEADT, 32'h80, rsp);
        repeat (2 * p) @(posedge ref_clk);
        hold_chk(4'h3, 4'h0, p);
        // dual mode: ch2 follows counter 2; freezing its transfer bit keeps old duty
        p2 = 30 + $urandom % 20;
        bus_wr(pwm_timer_pkg::OFS_DEADT, 32'h0, rsp);
        bus_wr(pwm_timer_pkg::OFS_RELOAD2, 32'(4096 - p2), rsp);
        bus_wr(pwm_timer_pkg::OFS_DUTY2, 32'(4096 - p2 + 5), rsp);
        bus_wr(pwm_timer_pkg::OFS_CTRL, 32'h7, rsp);
        measure(2, hi, per);
        measure(2, hi, per);
        chk(32'(per), 32'(p2));
        chk(32'(hi), 32'h5);
        bus_wr(pwm_timer_pkg::OFS_CTRL, 32'h3, rsp);
        bus_wr(pwm_timer_pkg::OFS_DUTY2, 32'(4096 - p2 + 9), rsp);
        repeat (2 * p2) @(posedge ref_clk);
        measure(2, hi, per);
        chk(32'(hi), 32'h5);
        // back to single mode with a forced update of counter 1 in the same write
        bus_wr(pwm_timer_pkg::OFS_CTRL, 32'he, rsp);
        bus_rd(pwm_timer_pkg::OFS_CNT1, rd, rsp);
        chk(32'(rd >= 32'(4096 - p) && rd < 32'(4100 - p)), 32'h1);
        bus_wr(pwm_timer_pkg::OFS_OUTC, 32'h5, rsp);
        hold_chk(4'ha, 4'h0, 8);
        chk(32'(pulse_output_oe), 32'h5);
        bus_wr(pwm_timer_pkg::OFS_OUTC, 32'hf, rsp);
        // pin break: pattern a, pin enabled, active high on pin 0
        bus_wr(pwm_timer_pkg::OFS_BREN, 32'h1, rsp);
        bus_wr(pwm_timer_pkg::OFS_BRK1, 32'h3a, rsp);
        @(posedge ref_clk);
        trip <= 1'b1;
        wait_pins(4'ha);
        hold_chk(4'hf, 4'ha, 8);
        bus_rd(pwm_timer_pkg::OFS_RELOAD1, rd, rsp);
        chk(rd, 32'h0);
        bus_rd(pwm_timer_pkg::OFS_CNT1, rd, rsp);
        chk(rd, 32'h0);
        bus_rd(pwm_timer_pkg::OFS_BRK1, rd, rsp);
        chk(32'(rd[7]), 32'h1);
        @(posedge ref_clk);
        trip <= 1'b0;
        // after a break the counter restarts from zero with zero duty: low until it wraps
        bus_wr(pwm_timer_pkg::OFS_BRK1, 32'h3a, rsp);
        wait_pins(4'h0);
        bus_wr(pwm_timer_pkg::OFS_BRK1, 32'h85, rsp);
        wait_pins(4'h5);
        bus_wr(pwm_timer_pkg::OFS_BRK1, 32'h0, rsp);
        wait_pins(4'h0);
        end_of_test();
    end
endmodule : dual_autoreload_pwm_timer_tb

// ---- testbench/half_bridge_stage.sv ----
// partner model: half-bridge power stage that also sources the break pins
module half_bridge_stage (
    // clock
    input  wire logic       ref_clk,
    // pwm pins from the timer
    input  wire logic [3:0] pulse_output,
    input  wire logic [3:0] pulse_output_oe,
    // fault command from the bench
    input  wire logic       trip,
    // break pins and shoot-through count
    output      logic [1:0] break_input_pin,
    output      int         overlap_cnt
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////////////
    // break pins idle low through pull-downs, a fault drives pin 0 to its active level
    assign break_input_pin = {1'b0, trip};

    ////////////////////////////////////////////////////////////////////////////////
    // both switches of one leg on together would short the supply
    initial overlap_cnt = 0;
    always @(posedge ref_clk) begin
        if (&pulse_output[1:0] && &pulse_output_oe[1:0]) begin
            overlap_cnt <= overlap_cnt + 1;
        end
    end
endmodule : half_bridge_stage
